//--- common/lcr_pkg.sv
// Shared constants for the line unit control and interrupt register bank.
// Assumes one 10 MHz clock and a parallel register port fed by the serial host port.
package lcr_pkg;
    // Register offsets
    localparam logic [5:0] ADDR_REDUNDANCY  = 6'h00;
    localparam logic [5:0] ADDR_INT_ENABLE  = 6'h01;
    localparam logic [5:0] ADDR_INT_STATUS  = 6'h02;
    localparam logic [5:0] ADDR_ALARM       = 6'h03;
    localparam logic [5:0] ADDR_GLOBAL_EN   = 6'h20;
    localparam logic [5:0] ADDR_GLOBAL_STAT = 6'h21;
    localparam logic [5:0] ADDR_CNT_HIGH    = 6'h30;
    localparam logic [5:0] ADDR_CNT_LOW     = 6'h31;
    localparam logic [5:0] ADDR_CNT_HOLD    = 6'h38;
    localparam logic [5:0] ADDR_PART_ID     = 6'h3e;
    localparam logic [5:0] ADDR_REVISION    = 6'h3f;
    // Field positions
    localparam int BIT_TX_ON   = 0;
    localparam int BIT_RX_ON   = 4;
    localparam int BIT_GIE     = 0;
    localparam int IRQ_DRV     = 0;
    localparam int IRQ_LOS     = 1;
    localparam int IRQ_LOL     = 2;
    localparam int IRQ_FIFO    = 3;
    localparam int IRQ_PRBS    = 4;
    localparam int IRQ_SAT     = 5;
    // Writable bits; everything else is reserved and reads zero
    localparam logic [7:0] MASK_REDUNDANCY = 8'h11;
    localparam logic [7:0] MASK_IRQ        = 8'h3f;
    localparam logic [7:0] MASK_GIE        = 8'h01;
    // Values after reset
    localparam logic [7:0] RST_REG  = 8'h00;
    localparam logic [3:0] RST_LVL  = 4'h0;
    // Counts
    localparam int DRV_SILENT_BITS   = 128;
    localparam int PRBS_CNT_WIDTH    = 16;
    localparam logic [15:0] PRBS_SAT = 16'hffff;
endpackage

//--- rtl/lcr_pulse_monitor.sv
// Driver monitor: flags a fault after a run of bit periods with no pulse.
// Assumes i_bit_tick is a one-cycle strobe per bit period, synchronous to i_mclk.
`timescale 1ns/10ps
module lcr_pulse_monitor #(
    parameter int SILENT_BITS = lcr_pkg::DRV_SILENT_BITS
) (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_bit_tick,
    input  wire logic i_mon_pulse,
    output logic      o_fault
);
    localparam int CW = $clog2(SILENT_BITS + 1);
    localparam logic [CW-1:0] LIMIT = CW'(SILENT_BITS);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          fault_reg;
    logic          fault_next;

    // Count silent bit periods; count saturates so the fault holds
    always_comb begin
        cnt_next = cnt_reg;
        if (i_mon_pulse) begin
            cnt_next = '0;
        end else if (i_bit_tick && cnt_reg != LIMIT) begin
            cnt_next = cnt_reg + 1'b1;
        end
        fault_next = (cnt_next == LIMIT); // R18
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cnt_reg   <= '0;
            fault_reg <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            fault_reg <= fault_next;
        end
    end

    assign o_fault = fault_reg;

    property p_fault_rise;
        @(posedge i_mclk) disable iff (!i_rst_n)
        $rose(fault_reg) |-> $past(i_bit_tick) && !$past(i_mon_pulse)
            && $past(cnt_reg) == LIMIT - 1'b1;
    endproperty
    a_fault_rise: assert property (p_fault_rise) else $error("fault rose early"); // R18
endmodule // lcr_pulse_monitor

//--- rtl/lcr_prbs_counter.sv
// Saturating counter of PRBS bit errors with a pulse on reaching saturation.
// Assumes i_err is a one-cycle pulse per detected bit error.
`timescale 1ns/10ps
module lcr_prbs_counter #(
    parameter int WIDTH = lcr_pkg::PRBS_CNT_WIDTH
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    input  wire logic             i_err,
    output logic [WIDTH-1:0]      o_count,
    output logic                  o_sat_pulse
);
    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;
    logic             sat_reg;
    logic             sat_next;

    // Stop at all ones so software sees a clean full-scale value
    always_comb begin
        cnt_next = cnt_reg;
        if (i_err && !(&cnt_reg)) begin
            cnt_next = cnt_reg + 1'b1;
        end
        sat_next = (&cnt_next) && !(&cnt_reg); // R9
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cnt_reg <= '0;
            sat_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            sat_reg <= sat_next;
        end
    end

    assign o_count     = cnt_reg;
    assign o_sat_pulse = sat_reg;

    property p_sat_full;
        @(posedge i_mclk) disable iff (!i_rst_n)
        o_sat_pulse |-> (&o_count) && $past(i_err);
    endproperty
    a_sat_full: assert property (p_sat_full) else $error("saturation pulse wrong"); // R15
endmodule // lcr_prbs_counter

//--- rtl/lcr_regs.sv
// Control, interrupt and identity register bank of a single-channel line unit.
// Assumes the serial host port presents decoded read and write strobes.
//
// Function
// [R1] Redundancy bit 4 turns the receiver on when one, off when zero.
// [R2] Redundancy bit 0 turns transmitter on; zero tri-states the line output.
// [R3] Enable bit D0 passes driver failure interrupts; zero masks them.
// [R4] Enable bit D1 passes signal loss interrupts; zero masks them.
// [R5] Enable bit D2 passes lock loss interrupts; zero masks them.
// [R6] Enable bit D3 passes FIFO within two bits of limit interrupts.
// [R7] With jitter attenuator disabled the FIFO-limit interrupt never fires.
// [R8] Enable bit D4 passes an interrupt on each PRBS bit error.
// [R9] Enable bit D5 interrupts when the PRBS error counter reaches 0xFFFF.
// [R10] Status D0 latches driver fault changes; read clears it.
// [R11] Status D1 latches signal loss changes; read clears it.
// [R12] Status D2 latches lock loss changes; read clears it.
// [R13] Status D3 latches FIFO-limit changes; read clears it.
// [R14] Status D4 sets on a PRBS bit error; read clears it.
// [R15] Status D5 sets on counter saturation; read clears it.
// [R16] Part identity register is an 8-bit read-only code; writes ignored.
// [R17] Pending enabled interrupts drive an active-low interrupt pin.
// [R18] Driver fault declared after 128 bit periods without pulses.
// [R19] Reading the FIFO-limit alarm resets the jitter FIFO.
// [R20] Interrupt asserts only with global enable and an enabled status bit.
// [R21] Error count read high then low; holding copy keeps low byte coherent.
// [R22] Control, enable and status bits reset to zero; reserved bits read zero.
`timescale 1ns/10ps
module lcr_regs #(
    parameter logic [7:0] PART_ID  = 8'h5a, // Arbitrary value
    parameter logic [7:0] REVISION = 8'h01  // Arbitrary value
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic [5:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic       i_rx_los,
    input  wire logic       i_rx_lol,
    input  wire logic       i_fifo_limit,
    input  wire logic       i_ja_enabled,
    input  wire logic       i_prbs_err,
    input  wire logic       i_bit_tick,
    input  wire logic       i_mon_pulse,
    input  wire logic       i_tx_pos,
    input  wire logic       i_tx_neg,
    output logic [7:0]      o_reg_rdata,
    output logic            o_reg_rvalid,
    output logic            o_irq_n,
    output logic            o_rx_on,
    output logic            o_tx_on,
    output logic            o_line_out_positive,
    output logic            o_line_out_negative,
    output logic            o_line_out_oe_n,
    output logic            o_fifo_reset
);
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [7:0]  ien_reg;
    logic [7:0]  ien_next;
    logic [7:0]  gie_reg;
    logic [7:0]  gie_next;
    logic [7:0]  stat_reg;
    logic [7:0]  stat_next;
    logic [3:0]  lvl_prev_reg;
    logic [7:0]  hold_reg;
    logic [7:0]  hold_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        rvalid_reg;
    logic        fifo_rst_reg;
    logic        fifo_rst_next;
    logic        irq_n_reg;
    logic        irq_n_next;
    logic        pos_reg;
    logic        neg_reg;
    logic        oe_n_reg;
    logic        drv_fault;
    logic        sat_pulse;
    logic [15:0] prbs_count;
    logic [3:0]  lvl;
    logic [7:0]  events;
    logic [7:0]  irq_src;
    logic        pending;
    logic        rd_status;

    // Driver monitor fault detector
    lcr_pulse_monitor #(
        .SILENT_BITS (lcr_pkg::DRV_SILENT_BITS)
    ) lcr_pulse_monitor_inst (
        .i_mclk      (i_mclk),
        .i_rst_n     (i_rst_n),
        .i_bit_tick  (i_bit_tick),
        .i_mon_pulse (i_mon_pulse),
        .o_fault     (drv_fault)
    );

    // PRBS error counter
    lcr_prbs_counter #(
        .WIDTH       (lcr_pkg::PRBS_CNT_WIDTH)
    ) lcr_prbs_counter_inst (
        .i_mclk      (i_mclk),
        .i_rst_n     (i_rst_n),
        .i_err       (i_prbs_err),
        .o_count     (prbs_count),
        .o_sat_pulse (sat_pulse)
    );

    // Alarm levels and the events that set status
    assign lvl = {i_fifo_limit, i_rx_lol, i_rx_los, drv_fault};
    assign events = {2'b00, sat_pulse, i_prbs_err, lvl ^ lvl_prev_reg}; // R10 R11 R12 R13 R14 R15
    assign rd_status = i_reg_rd && i_reg_addr == lcr_pkg::ADDR_INT_STATUS;

    // FIFO-limit source is dropped while the attenuator is off, whatever its enable
    always_comb begin
        irq_src = stat_reg & ien_reg; // R3 R4 R5 R6 R8 R9
        if (!i_ja_enabled) begin
            irq_src[lcr_pkg::IRQ_FIFO] = 1'b0; // R7
        end
        pending = gie_reg[lcr_pkg::BIT_GIE] && (|irq_src); // R20
    end

    // Writable registers; reserved bits are masked off on write
    always_comb begin
        ctrl_next = ctrl_reg;
        ien_next  = ien_reg;
        gie_next  = gie_reg;
        if (i_reg_wr) begin
            if (i_reg_addr == lcr_pkg::ADDR_REDUNDANCY) begin
                ctrl_next = i_reg_wdata & lcr_pkg::MASK_REDUNDANCY; // R1 R2 R22
            end else if (i_reg_addr == lcr_pkg::ADDR_INT_ENABLE) begin
                ien_next = i_reg_wdata & lcr_pkg::MASK_IRQ; // R22
            end else if (i_reg_addr == lcr_pkg::ADDR_GLOBAL_EN) begin
                gie_next = i_reg_wdata & lcr_pkg::MASK_GIE; // R22
            end
        end
    end

    // Sticky status: a new event in the read cycle survives the clear
    always_comb begin
        stat_next = (rd_status ? lcr_pkg::RST_REG : stat_reg) | events; // R10 R11 R12 R13
    end

    // Read mux and read side effects
    always_comb begin
        rdata_next    = 8'h00;
        hold_next     = hold_reg;
        fifo_rst_next = 1'b0;
        if (i_reg_rd) begin
            if (i_reg_addr == lcr_pkg::ADDR_REDUNDANCY) begin
                rdata_next = ctrl_reg;
            end else if (i_reg_addr == lcr_pkg::ADDR_INT_ENABLE) begin
                rdata_next = ien_reg;
            end else if (i_reg_addr == lcr_pkg::ADDR_INT_STATUS) begin
                rdata_next = stat_reg;
            end else if (i_reg_addr == lcr_pkg::ADDR_ALARM) begin
                rdata_next    = {4'h0, lvl};
                fifo_rst_next = 1'b1; // R19
            end else if (i_reg_addr == lcr_pkg::ADDR_GLOBAL_EN) begin
                rdata_next = gie_reg;
            end else if (i_reg_addr == lcr_pkg::ADDR_GLOBAL_STAT) begin
                rdata_next = {7'h00, pending};
            end else if (i_reg_addr == lcr_pkg::ADDR_CNT_HIGH) begin
                rdata_next = prbs_count[15:8];
                hold_next  = prbs_count[7:0]; // R21
            end else if (i_reg_addr == lcr_pkg::ADDR_CNT_LOW) begin
                rdata_next = hold_reg; // R21
            end else if (i_reg_addr == lcr_pkg::ADDR_CNT_HOLD) begin
                rdata_next = hold_reg;
            end else if (i_reg_addr == lcr_pkg::ADDR_PART_ID) begin
                rdata_next = PART_ID; // R16
            end else if (i_reg_addr == lcr_pkg::ADDR_REVISION) begin
                rdata_next = REVISION;
            end
        end
    end

    // Interrupt pin is registered so it cannot glitch on decode
    always_comb begin
        irq_n_next = !pending; // R17
    end

    // Register stage for all state
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ctrl_reg     <= lcr_pkg::RST_REG;
            ien_reg      <= lcr_pkg::RST_REG;
            gie_reg      <= lcr_pkg::RST_REG;
            stat_reg     <= lcr_pkg::RST_REG;
            lvl_prev_reg <= lcr_pkg::RST_LVL;
            hold_reg     <= lcr_pkg::RST_REG;
            rdata_reg    <= lcr_pkg::RST_REG;
            rvalid_reg   <= 1'b0;
            fifo_rst_reg <= 1'b0;
            irq_n_reg    <= 1'b1;
            pos_reg      <= 1'b0;
            neg_reg      <= 1'b0;
            oe_n_reg     <= 1'b1;
        end else begin
            ctrl_reg     <= ctrl_next;
            ien_reg      <= ien_next;
            gie_reg      <= gie_next;
            stat_reg     <= stat_next;
            lvl_prev_reg <= lvl;
            hold_reg     <= hold_next;
            rdata_reg    <= rdata_next;
            rvalid_reg   <= i_reg_rd;
            fifo_rst_reg <= fifo_rst_next;
            irq_n_reg    <= irq_n_next;
            pos_reg      <= ctrl_reg[lcr_pkg::BIT_TX_ON] && i_tx_pos;
            neg_reg      <= ctrl_reg[lcr_pkg::BIT_TX_ON] && i_tx_neg;
            oe_n_reg     <= !ctrl_reg[lcr_pkg::BIT_TX_ON]; // R2
        end
    end

    assign o_reg_rdata         = rdata_reg;
    assign o_reg_rvalid        = rvalid_reg;
    assign o_irq_n             = irq_n_reg;
    assign o_rx_on             = ctrl_reg[lcr_pkg::BIT_RX_ON]; // R1
    assign o_tx_on             = ctrl_reg[lcr_pkg::BIT_TX_ON]; // R2
    assign o_line_out_positive = pos_reg;
    assign o_line_out_negative = neg_reg;
    assign o_line_out_oe_n     = oe_n_reg;
    assign o_fifo_reset        = fifo_rst_reg;

    // Checks on the register bank
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    sequence s_write(logic [5:0] a);
        i_reg_wr && i_reg_addr == a;
    endsequence

    sequence s_read(logic [5:0] a);
        i_reg_rd && i_reg_addr == a;
    endsequence

    property p_rx_on;
        s_write(lcr_pkg::ADDR_REDUNDANCY) |=> o_rx_on == $past(i_reg_wdata[4]);
    endproperty
    a_rx_on: assert property (p_rx_on) else $error("receiver enable wrong"); // R1

    property p_tx_hiz;
        s_write(lcr_pkg::ADDR_REDUNDANCY) ##1 !o_tx_on |=> o_line_out_oe_n && !o_line_out_positive;
    endproperty
    a_tx_hiz: assert property (p_tx_hiz) else $error("line not released"); // R2

    property p_irq_raise;
        pending |=> !o_irq_n;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("irq missed"); // R3 R4 R5 R6 R8 R9 R17

    property p_irq_gate;
        !o_irq_n |-> $past(gie_reg[0]) && ($past(stat_reg & ien_reg) != 8'h00);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without cause"); // R20

    property p_fifo_ignored;
        !i_ja_enabled && ((stat_reg & ien_reg & 8'h37) == 8'h00) |=> o_irq_n;
    endproperty
    a_fifo_ignored: assert property (p_fifo_ignored) else $error("fifo irq leaked"); // R7

    property p_los_latch;
        $changed(i_rx_los) && $past(i_rst_n) |=> stat_reg[1];
    endproperty
    a_los_latch: assert property (p_los_latch) else $error("signal loss not latched"); // R11

    property p_drv_latch;
        $rose(drv_fault) |=> stat_reg[0];
    endproperty
    a_drv_latch: assert property (p_drv_latch) else $error("driver fault not latched"); // R10

    property p_read_clear;
        s_read(lcr_pkg::ADDR_INT_STATUS) ##0 (events == 8'h00) |=> stat_reg == 8'h00;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status not cleared"); // R12 R13

    property p_prbs_set;
        i_prbs_err |=> stat_reg[4];
    endproperty
    a_prbs_set: assert property (p_prbs_set) else $error("prbs flag lost"); // R14

    property p_sat_set;
        sat_pulse |=> stat_reg[5] ##0 (prbs_count == lcr_pkg::PRBS_SAT);
    endproperty
    a_sat_set: assert property (p_sat_set) else $error("saturation flag lost"); // R15

    property p_id_read;
        s_read(lcr_pkg::ADDR_PART_ID) |=> o_reg_rvalid && o_reg_rdata == PART_ID;
    endproperty
    a_id_read: assert property (p_id_read) else $error("identity wrong"); // R16

    property p_hold;
        s_read(lcr_pkg::ADDR_CNT_HIGH) |=> hold_reg == $past(prbs_count[7:0]);
    endproperty
    a_hold: assert property (p_hold) else $error("holding copy wrong"); // R21

    property p_fifo_reset;
        s_read(lcr_pkg::ADDR_ALARM) |=> o_fifo_reset ##1 !o_fifo_reset || $past(i_reg_rd);
    endproperty
    a_fifo_reset: assert property (p_fifo_reset) else $error("fifo reset missing"); // R19
endmodule // lcr_regs

//--- tb/lcr_host.sv
// Host processor model: issues register writes and reads on the parallel register port.
// Assumes the port takes one strobe per access and answers a read one cycle later.
`timescale 1ns/10ps
module lcr_host (
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    output logic [5:0]      o_addr,
    output logic [7:0]      o_wdata,
    output logic            o_wr,
    output logic            o_rd,
    output logic            o_stuck
);
    // Idle port at time zero
    initial begin
        o_addr = 6'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_stuck = 1'b0;
    end

    // Random idle gaps mimic a slow host; released data is inverted, not left stale
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        repeat ($urandom % 3) @(negedge i_mclk);
        @(negedge i_mclk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_mclk);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask

    // Answer is taken at the falling edge after the read edge, where it stands
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        repeat ($urandom % 3) @(negedge i_mclk);
        @(negedge i_mclk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_mclk);
        o_rd = 1'b0;
        o_addr = ~a;
        o_stuck = (i_rvalid !== 1'b1);
        d = i_rdata;
    endtask
endmodule // lcr_host

//--- tb/lcr_regs_tb_top.sv
// Self-checking bench for the line unit register bank, driven through the host model.
// Assumes lcr_pkg and lcr_host are compiled first.
`timescale 1ns/10ps
module lcr_regs_tb_top;
    localparam logic [7:0] PID   = 8'h5a; // Arbitrary value
    localparam logic [7:0] REV   = 8'h01; // Arbitrary value
    localparam int         LIMIT = 90000;
    localparam logic [5:0] ZADDR [6] = '{6'h00, 6'h01, 6'h02, 6'h20, 6'h21, 6'h10};
    logic       mclk, rst_n, los, lol, flim, ja, perr, tick, mpulse, txp, txn;
    logic [5:0] addr;
    logic [7:0] wdata, rdata;
    logic       wr, rd, rvalid, stuck, irq_n, rx_on, tx_on, lp, ln, oe_n, fifo_rst;
    int         n_mismatch, checks, cycles, nerr;

    lcr_regs #(.PART_ID(PID), .REVISION(REV)) lcr_regs_inst (
        .i_mclk(mclk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_rx_los(los), .i_rx_lol(lol),
        .i_fifo_limit(flim), .i_ja_enabled(ja), .i_prbs_err(perr), .i_bit_tick(tick),
        .i_mon_pulse(mpulse), .i_tx_pos(txp), .i_tx_neg(txn), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .o_irq_n(irq_n), .o_rx_on(rx_on), .o_tx_on(tx_on),
        .o_line_out_positive(lp), .o_line_out_negative(ln), .o_line_out_oe_n(oe_n),
        .o_fifo_reset(fifo_rst));

    lcr_host lcr_host_inst (
        .i_mclk(mclk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_stuck(stuck));

    // 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Expected interrupt pin; the FIFO source is dead while the attenuator is off
    function automatic logic irq_n_exp(input logic [7:0] st, en, input logic gie, jae);
        logic [7:0] live;
        live = st & en & lcr_pkg::MASK_IRQ;
        live[lcr_pkg::IRQ_FIFO] = live[lcr_pkg::IRQ_FIFO] & jae;
        return ~(gie & (|live));
    endfunction

    // Expected pins after a redundancy write: line data only passes while driving
    function automatic logic [7:0] pins_exp(input logic [7:0] d, input logic p, n);
        return {3'h0, d[4], d[0], ~d[0], p & d[0], n & d[0]};
    endfunction

    task automatic conclude();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A read that brings no answer compares as unknown, so it always fails
    task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        lcr_host_inst.rd(a, d);
        // Read the flag in the host itself: the port copy may not have settled yet
        chk(lcr_host_inst.o_stuck ? 8'hxx : d, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Make one event on a source: levels toggle, the error input pulses
    task automatic kick(input int i);
        case (i)
            1: los = ~los;
            2: lol = ~lol;
            3: flim = ~flim;
            default: begin
                perr = 1'b1;
                nerr++;
                cyc(1);
                perr = 1'b0;
            end
        endcase
    endtask

    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        logic [7:0] d, en;
        logic       g;
        int         n;
        {los, lol, flim, ja, perr, tick, mpulse, txp, txn} = 9'h000;
        rst_n = 1'b0;
        n_mismatch = 0;
        checks = 0;
        cycles = 0;
        nerr = 0;
        void'($urandom(32'h3faf));
        cyc(20);
        rst_n = 1'b1;
        // Reset values, identity, reserved space
        chk({3'h0, irq_n, rx_on, tx_on, oe_n, fifo_rst}, 8'h12);
        foreach (ZADDR[k]) rchk(ZADDR[k], 8'h00);
        lcr_host_inst.wr(lcr_pkg::ADDR_PART_ID, ~PID);
        rchk(lcr_pkg::ADDR_PART_ID, PID);
        rchk(lcr_pkg::ADDR_REVISION, REV);
        lcr_host_inst.wr(lcr_pkg::ADDR_GLOBAL_EN, 8'hfe);
        rchk(lcr_pkg::ADDR_GLOBAL_EN, 8'h00);
        // Receiver and transmitter control, all-ones and all-zeros first
        for (int k = 0; k < 6; k++) begin
            d = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
            lcr_host_inst.wr(lcr_pkg::ADDR_REDUNDANCY, d);
            txp = 1'($urandom);
            txn = 1'($urandom);
            cyc(2);
            chk({3'h0, rx_on, tx_on, oe_n, lp, ln}, pins_exp(d, txp, txn));
            rchk(lcr_pkg::ADDR_REDUNDANCY, d & lcr_pkg::MASK_REDUNDANCY);
        end
        // Sources D1 to D4 (signal loss, lock loss, FIFO, PRBS): enabled, masked, global off, attenuator off
        for (int i = 1; i < 5; i++) begin
            for (int m = 0; m < 4; m++) begin
                en = (m == 1) ? 8'h00 : 8'h01 << i;
                g = (m != 2);
                ja = (m != 3);
                lcr_host_inst.wr(lcr_pkg::ADDR_INT_ENABLE, en);
                lcr_host_inst.wr(lcr_pkg::ADDR_GLOBAL_EN, {7'h00, g});
                kick(i);
                cyc(3);
                chk({7'h00, irq_n}, {7'h00, irq_n_exp(8'h01 << i, en, g, ja)});
                rchk(lcr_pkg::ADDR_GLOBAL_STAT, {7'h00, ~irq_n_exp(8'h01 << i, en, g, ja)});
                rchk(lcr_pkg::ADDR_INT_STATUS, 8'h01 << i);
                rchk(lcr_pkg::ADDR_INT_STATUS, 8'h00);
                chk({7'h00, irq_n}, 8'h01);
            end
        end
        // Driver monitor: silence for 132 bit periods, past the 128 limit, then a pulse
        lcr_host_inst.wr(lcr_pkg::ADDR_INT_ENABLE, 8'h01);
        tick = 1'b1;
        cyc(120);
        chk({7'h00, irq_n}, 8'h01);
        cyc(12);
        chk({7'h00, irq_n}, 8'h00);
        tick = 1'b0;
        rchk(lcr_pkg::ADDR_INT_STATUS, 8'h01);
        mpulse = 1'b1;
        cyc(1);
        mpulse = 1'b0;
        cyc(3);
        rchk(lcr_pkg::ADDR_INT_STATUS, 8'h01);
        // Reading the FIFO alarm resets the jitter FIFO
        ja = 1'b1;
        kick(3);
        cyc(2);
        lcr_host_inst.rd(lcr_pkg::ADDR_ALARM, d);
        chk({7'h00, fifo_rst}, 8'h01);
        chk(d, 8'h08);
        rchk(lcr_pkg::ADDR_INT_STATUS, 8'h08);
        // Error count bursts, read high byte then low byte and holding copy
        for (int b = 0; b < 3; b++) begin
            n = 1 + $urandom % 300;
            perr = 1'b1;
            cyc(n);
            perr = 1'b0;
            nerr += n;
            rchk(lcr_pkg::ADDR_CNT_HIGH, 8'(nerr >> 8));
            rchk(lcr_pkg::ADDR_CNT_LOW, 8'(nerr));
            rchk(lcr_pkg::ADDR_CNT_HOLD, 8'(nerr));
        end
        // Saturation: count holds at its ceiling and raises its own source
        lcr_host_inst.wr(lcr_pkg::ADDR_INT_ENABLE, 8'h20);
        rchk(lcr_pkg::ADDR_INT_STATUS, 8'h10);
        perr = 1'b1;
        cyc(65540 - nerr);
        perr = 1'b0;
        cyc(3);
        chk({7'h00, irq_n}, 8'h00);
        rchk(lcr_pkg::ADDR_CNT_HIGH, 8'hff);
        rchk(lcr_pkg::ADDR_CNT_LOW, 8'hff);
        rchk(lcr_pkg::ADDR_INT_STATUS, 8'h30);
        conclude();
    end
endmodule // lcr_regs_tb_top
